// *** rtl/irq_rank.v ***
// Purpose: rank enabled interrupt sources and hold the reported one
// Assumes: all inputs come from logic on clk
// Notes: id_reg is held while freeze is high
`timescale 1ns/1ps
`include "uart_lc_defs.vh"

module irq_rank (
  input wire clk, // system clock
  input wire srst, // synchronous reset, active high
  input wire ce, // clock enable
  input wire [3:0] enable, // interrupt enable bits 3:0
  input wire rda_pend, // received data ready
  input wire tx_hold_empty_pend, // holding register empty
  input wire rls_pend, // receiver line status
  input wire ms_pend, // modem status
  input wire freeze, // identification register addressed
  output reg [2:0] id_reg, // {code, pending_n}
  output wire irq // any enabled source pending
);

  wire [3:0] act;

  assign act = enable & {ms_pend, rls_pend, tx_hold_empty_pend, rda_pend};
  assign irq = |act;

  // =============================================================
  // priority encoder
  function [2:0] rank;
    input [3:0] a;
    begin
      if (a[`IER_RLS])
        rank = `IIR_RLS;
      else if (a[`IER_RDA])
        rank = `IIR_RDA;
      else if (a[`IER_TX_HOLD_EMPTY])
        rank = `IIR_TX_HOLD_EMPTY;
      else if (a[`IER_MS])
        rank = `IIR_MS;
      else
        rank = `IIR_NONE;
    end
  endfunction

  always @(posedge clk)
  begin
    if (srst)
      id_reg <= `IIR_NONE;
    else if (ce && !freeze)
      id_reg <= rank(act);
  end

endmodule // irq_rank

// *** rtl/modem_status.v ***
// Purpose: handshake_input_status register with change flags
// Assumes: cts, dsr, ri, dcd are asynchronous pins, active high
// Notes: change flags clear on read, a new change wins over the clear
`timescale 1ns/1ps

module modem_status (
  input wire clk, // system clock
  input wire srst, // synchronous reset, active high
  input wire ce, // clock enable
  input wire [3:0] pins, // {dcd, ri, dsr, cts} raw
  input wire clear, // register read
  output wire [7:0] status // register value
);

  reg [3:0] meta_reg;
  reg [3:0] sync_reg;
  reg [3:0] prev_reg;
  reg [3:0] flag_reg;
  reg primed_reg;
  wire [3:0] chg;
  wire [3:0] set;

  assign chg = sync_reg ^ prev_reg;
  // bit 2 only on ring trailing edge
  assign set = {4{primed_reg}} & {chg[3], prev_reg[2] & ~sync_reg[2], chg[1], chg[0]};
  assign status = {sync_reg[3], ~sync_reg[2], sync_reg[1], sync_reg[0], flag_reg};

  always @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
      prev_reg <= 4'h0;
      flag_reg <= 4'h0;
      primed_reg <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      primed_reg <= 1'b1;
      flag_reg <= set | (flag_reg & ~{4{clear}});
    end
  end

endmodule // modem_status

// *** rtl/uart_irq_and_line_control.v ***
// Purpose: host side of a pc style uart: interrupts, line format, framing
// Assumes: cs, addr, rd, wr, din are synchronous to clk; rd and wr are pulses
// Notes: baud tick = clk / divisor, sixteen ticks per serial bit
// Contract
// - iir bit0 low when enabled interrupt pending
// - four priority levels encoded in iir bits 2:1
// - iir bits 7:3 read zero
// - addressing iir freezes reported source
// - ier bits 3:0 gate four sources
// - all enables clear: no id, no interrupt
// - status flags keep setting when disabled
// - ier bits 7:4 read one
// - lcr bits 1:0 select five to eight bits
// - lcr bit2 selects one or two stops
// - parity enable inserts and checks parity bit
// - lcr bit4 chooses odd or even parity
// - stick parity sends constant one
// - break bit holds output at space
// - three address lines select the registers
// - out2 low floats interrupt pin
// - ring edge or carrier change flags interrupt
`timescale 1ns/1ps
`include "uart_lc_defs.vh"

module uart_irq_and_line_control (
  input wire clk, // 125 MHz system clock
  input wire srst, // synchronous reset, active high
  input wire ce, // clock enable, freezes all state when low
  input wire cs, // chip select, active high
  input wire [2:0] addr, // register offset
  input wire rd, // read strobe pulse
  input wire wr, // write strobe pulse
  input wire [7:0] din, // write data
  output reg [7:0] dout_reg, // read data
  output reg dout_oe_n_reg, // read data enable, active low
  input wire sin, // serial input, asynchronous
  output reg sout_reg, // serial output
  input wire cts, // clear to send pin
  input wire dsr, // data set ready pin
  input wire ri, // ring indicator pin
  input wire dcd, // carrier detect pin
  output reg int_out_reg, // interrupt, active high
  output wire int_oe_n, // interrupt enable, low drives pin
  output wire dtr, // data terminal ready
  output wire rts, // request to send
  output wire out1 // general output 1
);

  localparam RX_IDLE = 3'b001;
  localparam RX_START = 3'b010;
  localparam RX_DATA = 3'b100;

  reg [3:0] ier_reg, tx_left_reg, tx_tick_reg, rx_tick_reg, rx_idx_reg;
  reg [7:0] lcr_reg, thr_reg, rbr_reg, rd_mux;
  reg [4:0] mcr_reg;
  reg [15:0] div_reg, div_cnt_reg;
  reg [11:0] tx_shift_reg, rx_bits_reg, tx_frame, rx_full;
  reg [2:0] rx_state_reg;
  reg tx_hold_empty_reg, tx_hold_empty_pend_reg, tx_busy_reg, sin_meta_reg, sin_sync_reg, rx_done;
  reg dr_reg, oe_reg, pe_reg, fe_reg, bi_reg;
  wire divisor_window_select, tick, irq, rx_pe, rx_fe;
  wire rd_hit, wr_hit, rd_rbr, rd_iir, rd_lsr, rd_msr, wr_thr, tx_load;
  wire [1:0] wl;
  wire [3:0] nbits, par_idx;
  wire [2:0] iir_id;
  wire [7:0] mask, serial_error_status, handshake_input_status, rx_data;

  // =============================================================
  // format helpers
  function par_bit;
    input [7:0] d;
    input [7:0] l;
    begin
      if (l[`LCR_STICK])
        par_bit = 1'b1;
      else
        par_bit = l[`LCR_EPS] ? ^d : ~^d;
    end
  endfunction

  assign divisor_window_select = lcr_reg[`LCR_DIVISOR_WINDOW_SELECT];
  assign wl = lcr_reg[1:0];
  assign mask = 8'hff >> (2'h3 - wl);
  // start + five data + one stop, plus length, parity, second stop
  assign nbits = 4'h7 + {2'h0, wl} + {3'h0, lcr_reg[`LCR_PEN]} +
                 {3'h0, lcr_reg[`LCR_STB]};
  assign par_idx = 4'h6 + {2'h0, wl};

  // =============================================================
  // register decode
  assign rd_hit = cs & rd;
  assign wr_hit = cs & wr;
  assign rd_rbr = rd_hit & (addr == `OFS_DATA) & ~divisor_window_select;
  assign rd_iir = rd_hit & (addr == `OFS_IIR);
  assign rd_lsr = rd_hit & (addr == `OFS_LSR);
  assign rd_msr = rd_hit & (addr == `OFS_MSR);
  assign wr_thr = wr_hit & (addr == `OFS_DATA) & ~divisor_window_select;

  assign serial_error_status = {1'b0, ~tx_busy_reg, tx_hold_empty_reg, bi_reg, fe_reg, pe_reg, oe_reg, dr_reg};
  assign dtr = mcr_reg[0];
  assign rts = mcr_reg[1];
  assign out1 = mcr_reg[2];
  assign int_oe_n = ~mcr_reg[`MCR_OUT2];

  always @*
  begin
    case (addr)
      `OFS_DATA: rd_mux = divisor_window_select ? div_reg[7:0] : rbr_reg;
      `OFS_IER: rd_mux = divisor_window_select ? div_reg[15:8] : {`IER_HIGH_ONES, ier_reg};
      `OFS_IIR: rd_mux = {5'h00, iir_id};
      `OFS_LCR: rd_mux = lcr_reg;
      `OFS_MCR: rd_mux = {3'h0, mcr_reg};
      `OFS_LSR: rd_mux = serial_error_status;
      `OFS_MSR: rd_mux = handshake_input_status;
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      ier_reg <= `RST_IER;
      lcr_reg <= `RST_LCR;
      mcr_reg <= `RST_MCR;
      div_reg <= `RST_DIV;
      dout_reg <= 8'h00;
      dout_oe_n_reg <= 1'b1;
      int_out_reg <= 1'b0;
    end
    else if (ce)
    begin
      dout_oe_n_reg <= ~rd_hit;
      if (rd_hit)
        dout_reg <= rd_mux;
      int_out_reg <= irq;
      if (wr_hit)
      begin
        case (addr)
          `OFS_DATA:
            if (divisor_window_select)
              div_reg[7:0] <= din;
          `OFS_IER:
            if (divisor_window_select)
              div_reg[15:8] <= din;
            else
              ier_reg <= din[3:0];
          `OFS_LCR: lcr_reg <= din;
          `OFS_MCR: mcr_reg <= din[4:0];
          default: mcr_reg <= mcr_reg;
        endcase
      end
    end
  end

  // =============================================================
  // baud tick
  assign tick = (div_cnt_reg == 16'h0000);

  always @(posedge clk)
  begin
    if (srst)
      div_cnt_reg <= 16'h0000;
    else if (ce)
      div_cnt_reg <= tick ? ((div_reg > 16'h0001) ? div_reg - 16'h0001 : 16'h0000)
                          : div_cnt_reg - 16'h0001;
  end

  // =============================================================
  // transmitter
  assign tx_load = ~tx_busy_reg & ~tx_hold_empty_reg & ~wr_thr;

  always @*
  begin
    tx_frame = {3'h7, thr_reg | ~mask, 1'b0};
    if (lcr_reg[`LCR_PEN])
      tx_frame[par_idx] = par_bit(thr_reg & mask, lcr_reg);
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      thr_reg <= 8'h00;
      tx_hold_empty_reg <= 1'b1;
      tx_hold_empty_pend_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 12'hfff;
      tx_left_reg <= 4'h0;
      tx_tick_reg <= 4'h0;
      sout_reg <= 1'b1;
    end
    else if (ce)
    begin
      if (wr_thr)
      begin
        thr_reg <= din;
        tx_hold_empty_reg <= 1'b0;
      end
      else if (tx_load)
        tx_hold_empty_reg <= 1'b1;
      // set on each refill wins over the service clear
      tx_hold_empty_pend_reg <= tx_load |
                       (tx_hold_empty_pend_reg & ~wr_thr & ~(rd_iir & (iir_id == `IIR_TX_HOLD_EMPTY)));
      if (tx_load)
      begin
        tx_busy_reg <= 1'b1;
        tx_shift_reg <= tx_frame;
        tx_left_reg <= nbits;
        tx_tick_reg <= 4'h0;
      end
      else if (tx_busy_reg && tick)
      begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
        if (tx_tick_reg == `TICK_LAST)
        begin
          tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
          if (tx_left_reg == 4'h1)
            tx_busy_reg <= 1'b0;
        end
      end
      sout_reg <= lcr_reg[`LCR_BRK] ? 1'b0 : (~tx_busy_reg | tx_shift_reg[0]);
    end
  end

  // =============================================================
  // receiver
  always @*
  begin
    rx_full = rx_bits_reg;
    rx_full[rx_idx_reg] = sin_sync_reg;
    rx_done = (rx_state_reg == RX_DATA) & tick & (rx_tick_reg == `TICK_LAST) &
              (rx_idx_reg == nbits - 4'h1);
  end

  assign rx_data = rx_full[8:1] & mask;
  assign rx_pe = lcr_reg[`LCR_PEN] & (rx_full[par_idx] != par_bit(rx_data, lcr_reg));
  assign rx_fe = ~rx_full[par_idx + {3'h0, lcr_reg[`LCR_PEN]}] |
                 (lcr_reg[`LCR_STB] & ~rx_full[nbits - 4'h1]);

  always @(posedge clk)
  begin
    if (srst)
    begin
      sin_meta_reg <= 1'b1;
      sin_sync_reg <= 1'b1;
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_idx_reg <= 4'h1;
      rx_bits_reg <= 12'h000;
      rbr_reg <= 8'h00;
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      bi_reg <= 1'b0;
    end
    else if (ce)
    begin
      sin_meta_reg <= sin;
      sin_sync_reg <= sin_meta_reg;
      if (tick)
      begin
        case (rx_state_reg)
          RX_IDLE:
            if (!sin_sync_reg)
            begin
              rx_state_reg <= RX_START;
              rx_tick_reg <= 4'h0;
            end
          RX_START:
          begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `TICK_MID)
            begin
              rx_state_reg <= sin_sync_reg ? RX_IDLE : RX_DATA;
              rx_tick_reg <= 4'h0;
              rx_idx_reg <= 4'h1;
              rx_bits_reg <= 12'h000;
            end
          end
          RX_DATA:
          begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `TICK_LAST)
            begin
              rx_bits_reg <= rx_full;
              rx_idx_reg <= rx_idx_reg + 4'h1;
              if (rx_done)
                rx_state_reg <= RX_IDLE;
            end
          end
          default: rx_state_reg <= RX_IDLE;
        endcase
      end
      if (rx_done)
        rbr_reg <= rx_data;
      // new events win over the read that services them
      dr_reg <= rx_done | (dr_reg & ~rd_rbr);
      oe_reg <= (rx_done & dr_reg) | (oe_reg & ~rd_lsr);
      pe_reg <= (rx_done & rx_pe) | (pe_reg & ~rd_lsr);
      fe_reg <= (rx_done & rx_fe) | (fe_reg & ~rd_lsr);
      bi_reg <= (rx_done & ~|rx_full) | (bi_reg & ~rd_lsr);
    end
  end

  // =============================================================
  // modem status and interrupt ranking
  modem_status u_modem_status (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pins({dcd, ri, dsr, cts}),
    .clear(rd_msr),
    .status(handshake_input_status)
  );

  irq_rank u_irq_rank (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .enable(ier_reg),
    .rda_pend(dr_reg),
    .tx_hold_empty_pend(tx_hold_empty_pend_reg),
    .rls_pend(oe_reg | pe_reg | fe_reg | bi_reg),
    .ms_pend(handshake_input_status[2] | handshake_input_status[3]),
    .freeze(cs & (addr == `OFS_IIR)),
    .id_reg(iir_id),
    .irq(irq)
  );

endmodule // uart_irq_and_line_control

// *** rtl/uart_lc_defs.vh ***
// Purpose: constants shared by the uart interrupt and line control block
// Assumes: registers are 8 bits wide, selected by a 3-bit offset
// Notes: field positions are bit numbers inside each register
`ifndef UART_LC_DEFS_VH
`define UART_LC_DEFS_VH

// =============================================================
// register offsets
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_IIR 3'h2
`define OFS_LCR 3'h3
`define OFS_MCR 3'h4
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6

// =============================================================
// line_format_control fields
`define LCR_STB 2
`define LCR_PEN 3
`define LCR_EPS 4
`define LCR_STICK 5
`define LCR_BRK 6
`define LCR_DIVISOR_WINDOW_SELECT 7

// =============================================================
// interrupt_enable_mask fields and fixed bits
`define IER_RDA 0
`define IER_TX_HOLD_EMPTY 1
`define IER_RLS 2
`define IER_MS 3
`define IER_HIGH_ONES 4'hf

// =============================================================
// handshake_output_control fields
`define MCR_OUT2 3

// =============================================================
// interrupt_source_id codes {id[2:1], pending_n}
`define IIR_RLS 3'h6
`define IIR_RDA 3'h4
`define IIR_TX_HOLD_EMPTY 3'h2
`define IIR_MS 3'h0
`define IIR_NONE 3'h1

// =============================================================
// reset values
`define RST_IER 4'h0
`define RST_LCR 8'h00
`define RST_MCR 5'h00
`define RST_DIV 16'h0060

// =============================================================
// timing: divisor ticks per bit, sample point inside a bit
`define TICK_LAST 4'hf
`define TICK_MID 4'h7

`endif

// *** tb/host_cpu_model.sv ***
// Purpose: host cpu on the parallel register bus
// Assumes: one access per call, driven at falling edge
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module host_cpu_model (
  input wire clk, // system clock
  output reg cs, // chip select
  output reg [2:0] addr, // offset
  output reg rd, // read strobe
  output reg wr, // write strobe
  output reg [7:0] din // write data
);
initial
begin
  cs = 1'b0;
  addr = 3'h0;
  rd = 1'b0;
  wr = 1'b0;
  din = 8'h5a;
end
task bus_op(input [2:0] a, input [7:0] d, input w);
begin
  @(negedge clk);
  cs = 1'b1;
  addr = a;
  din = d;
  rd = !w;
  wr = w;
  @(negedge clk);
  cs = 1'b0;
  rd = 1'b0;
  wr = 1'b0;
  addr = ~a;
  din = ~d;
end
endtask
task set_divisor(input [15:0] dv, input [7:0] fmt);
begin
  bus_op(3'h3, fmt | 8'h80, 1'b1);
  bus_op(3'h0, dv[7:0], 1'b1);
  bus_op(3'h1, dv[15:8], 1'b1);
  bus_op(3'h3, fmt & 8'h7f, 1'b1);
end
endtask
endmodule // host_cpu_model

// *** tb/tb_uart_irq_and_line_control.sv ***
// Purpose: self-checking bench for uart_irq_and_line_control
// Assumes: divisor 1, sixteen clocks per serial bit
// Notes: reads are queued and checked when data strobe shows
`timescale 1ns/1ps
module tb_uart_irq_and_line_control;
reg clk;
reg srst;
reg sin;
reg dcd;
wire cs;
wire [2:0] addr;
wire rd;
wire wr;
wire [7:0] din;
wire [7:0] dout_reg;
wire dout_oe_n_reg;
wire sout_reg;
wire int_out_reg;
wire int_oe_n;
integer failures;
integer check_count;
integer i;
reg [7:0] v;
reg [7:0] exp_q[$];
reg [7:0] fmts[0:5];
uart_irq_and_line_control u_dut (.clk(clk), .srst(srst), .ce(1'b1), .cs(cs), .addr(addr),
  .rd(rd), .wr(wr), .din(din), .dout_reg(dout_reg), .dout_oe_n_reg(dout_oe_n_reg),
  .sin(sin), .sout_reg(sout_reg), .cts(1'b0), .dsr(1'b0), .ri(1'b0), .dcd(dcd),
  .int_out_reg(int_out_reg), .int_oe_n(int_oe_n), .dtr(), .rts(), .out1());
host_cpu_model u_host (.clk(clk), .cs(cs), .addr(addr), .rd(rd), .wr(wr), .din(din));
// ====================
// checking
task cmp8(input [7:0] got, input [7:0] exp);
begin
  check_count = check_count + 1;
  if (got !== exp)
  begin
    failures = failures + 1;
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
  end
end
endtask
task cmp_bit(input got, input exp);
begin
  cmp8({7'h00, got}, {7'h00, exp});
end
endtask
task rdx(input [2:0] a, input [7:0] e);
begin
  exp_q.push_back(e);
  u_host.bus_op(a, 8'h00, 1'b0);
end
endtask
always @(negedge clk)
begin
  if (dout_oe_n_reg === 1'b0)
  begin
    if (exp_q.size() > 0)
      cmp8(dout_reg, exp_q.pop_front());
    else
    begin
      failures = failures + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, dout_reg, 8'hxx);
    end
  end
end
task stop_test;
begin
  // a read that never showed its data strobe leaves a note behind
  if (exp_q.size() != 0)
  begin
    failures = failures + 1;
    $display("BAD t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
  end
  $display("checks=%0d failures=%0d", check_count, failures);
  if (failures == 0 && check_count > 0)
    $display("verification passed");
  else
    $display("verification failed");
  $finish;
end
endtask
// ====================
// serial helpers
task tx_chk(input [7:0] f, input [7:0] d);
  reg [11:0] fr;
  integer n;
  integer k;
begin
  n = 5 + f[1:0];
  fr = 12'hfff;
  fr[0] = 1'b0;
  for (k = 0; k < n; k = k + 1)
    fr[k + 1] = d[k];
  if (f[3])
    fr[n + 1] = f[5] ? 1'b1 : (^(d & (8'hff >> (8 - n))) ^ !f[4]);
  u_host.bus_op(3'h0, d, 1'b1);
  k = 0;
  while (sout_reg !== 1'b0 && k < 400)
  begin
    @(negedge clk);
    k = k + 1;
  end
  repeat (7) @(negedge clk);
  for (k = 0; k < n + 2 + f[3] + f[2]; k = k + 1)
  begin
    cmp_bit(sout_reg, fr[k]);
    repeat (16) @(negedge clk);
  end
end
endtask
task rx_send(input [10:0] bits, input integer n);
  integer k;
begin
  for (k = 0; k < n; k = k + 1)
  begin
    sin = bits[k];
    repeat (16) @(negedge clk);
  end
  sin = 1'b1;
  repeat (6) @(negedge clk);
end
endtask
// ====================
// stimulus
initial
begin
  clk = 1'b0;
  forever #4 clk = ~clk;
end
initial
begin
  repeat (20000) @(posedge clk);
  failures = failures + 1;
  stop_test;
end
initial
begin
  failures = 0;
  check_count = 0;
  srst = 1'b1;
  sin = 1'b1;
  dcd = 1'b0;
  fmts[0] = 8'h03;
  fmts[1] = 8'h00;
  fmts[2] = 8'h0d;
  fmts[3] = 8'h1a;
  fmts[4] = 8'h3b;
  fmts[5] = 8'h06;
  v = $urandom(42036);
  repeat (2) @(negedge clk);
  srst = 1'b0;
  rdx(3'h2, 8'h01);
  rdx(3'h1, 8'hf0);
  rdx(3'h3, 8'h00);
  rdx(3'h7, 8'h00);
  for (i = 0; i < 3; i = i + 1)
  begin
    v = $urandom & 8'h3f;
    u_host.bus_op(3'h3, v, 1'b1);
    rdx(3'h3, v);
  end
  u_host.bus_op(3'h4, $urandom & 8'h0f, 1'b1);
  u_host.bus_op(3'h4, 8'h08, 1'b1);
  u_host.bus_op(3'h3, 8'h00, 1'b1);
  dcd = 1'b1;
  repeat (8) @(negedge clk);
  rdx(3'h2, 8'h01);
  rdx(3'h6, 8'hc8);
  u_host.bus_op(3'h1, 8'h08, 1'b1);
  dcd = 1'b0;
  repeat (8) @(negedge clk);
  rdx(3'h2, 8'h00);
  rdx(3'h6, 8'h48);
  rdx(3'h2, 8'h01);
  u_host.bus_op(3'h3, 8'h40, 1'b1);
  repeat (2) @(negedge clk);
  cmp_bit(sout_reg, 1'b0);
  u_host.set_divisor(16'h0001, 8'h00);
  cmp_bit(sout_reg, 1'b1);
  // the old divisor count drains before ticks come every clock
  repeat (100) @(negedge clk);
  for (i = 0; i < 6; i = i + 1)
  begin
    u_host.bus_op(3'h3, fmts[i], 1'b1);
    tx_chk(fmts[i], $urandom);
  end
  u_host.bus_op(3'h1, 8'h02, 1'b1);
  repeat (4) @(negedge clk);
  cmp_bit(int_out_reg, 1'b1);
  rdx(3'h2, 8'h02);
  rdx(3'h2, 8'h01);
  u_host.bus_op(3'h3, 8'h03, 1'b1);
  u_host.bus_op(3'h1, 8'h05, 1'b1);
  v = $urandom;
  rx_send({2'b11, v, 1'b0}, 10);
  rdx(3'h2, 8'h04);
  rdx(3'h0, v);
  rdx(3'h2, 8'h01);
  u_host.bus_op(3'h3, 8'h1b, 1'b1);
  rx_send({2'b11, 8'h00, 1'b0}, 11);
  rdx(3'h2, 8'h06);
  rdx(3'h5, 8'h65);
  rdx(3'h2, 8'h04);
  rdx(3'h0, 8'h00);
  rdx(3'h2, 8'h01);
  // reset again in mid-run with enables set
  srst = 1'b1;
  repeat (2) @(negedge clk);
  srst = 1'b0;
  rdx(3'h1, 8'hf0);
  rdx(3'h3, 8'h00);
  rdx(3'h2, 8'h01);
  rdx(3'h5, 8'h60);
  repeat (4) @(negedge clk);
  stop_test;
end
endmodule // tb_uart_irq_and_line_control

// *** tb/uart_lc_asserts.sv ***
// Purpose: port checks for uart_irq_and_line_control
// Assumes: bus synchronous to clk, ce held high in reset
// Notes: shadows of ier, lcr and mcr kept from host writes
`timescale 1ns/1ps
module uart_lc_asserts (
  input wire clk, // clock
  input wire srst, // sync reset
  input wire ce, // clock enable
  input wire cs, // chip select
  input wire [2:0] addr, // offset
  input wire rd, // read strobe
  input wire wr, // write strobe
  input wire [7:0] din, // write data
  input wire [7:0] dout_reg, // read data
  input wire dout_oe_n_reg, // read data valid_n
  input wire sin, // serial in
  input wire sout_reg, // serial out
  input wire cts, // modem pin
  input wire dsr, // modem pin
  input wire ri, // modem pin
  input wire dcd, // modem pin
  input wire int_out_reg, // interrupt
  input wire int_oe_n, // interrupt enable_n
  input wire dtr, // mcr bit 0
  input wire rts, // mcr bit 1
  input wire out1 // mcr bit 2
);
// ====================
// shadow registers
reg ier_zero_reg;
reg divisor_window_select_reg;
reg brk_reg;
reg [3:0] mcr_reg;
always @(posedge clk)
begin
  if (srst)
  begin
    ier_zero_reg <= 1'b1;
    divisor_window_select_reg <= 1'b0;
    brk_reg <= 1'b0;
    mcr_reg <= 4'h0;
  end
  else if (ce && cs && wr)
  begin
    if (addr == 3'h1 && !divisor_window_select_reg)
      ier_zero_reg <= (din[3:0] == 4'h0);
    if (addr == 3'h3)
    begin
      divisor_window_select_reg <= din[7];
      brk_reg <= din[6];
    end
    if (addr == 3'h4)
      mcr_reg <= din[3:0];
  end
end
// ====================
// properties
default clocking cb @(posedge clk); endclocking
default disable iff (srst);
sequence s_rd(logic [2:0] a);
  ce && cs && rd && addr == a;
endsequence
sequence s_off;
  ier_zero_reg [*3];
endsequence
property p_oe_pulse;
  (ce && cs && rd) |=> !dout_oe_n_reg;
endproperty
property p_oe_idle;
  (ce && !(cs && rd)) |=> dout_oe_n_reg;
endproperty
property p_iir_zero;
  s_rd(3'h2) |=> dout_reg[7:3] == 5'h00;
endproperty
property p_ier_ones;
  s_rd(3'h1) ##0 !divisor_window_select_reg |=> dout_reg[7:4] == 4'hf;
endproperty
property p_off_idle;
  s_off ##0 s_rd(3'h2) |=> dout_reg == 8'h01;
endproperty
property p_int_off;
  s_off |-> !int_out_reg;
endproperty
property p_mcr_pins;
  {int_oe_n, out1, rts, dtr} == {!mcr_reg[3], mcr_reg[2:0]};
endproperty
property p_break;
  brk_reg [*2] |-> !sout_reg;
endproperty
property p_scratch;
  s_rd(3'h7) |=> dout_reg == 8'h00;
endproperty
property p_reset;
  disable iff (!ce) srst |=> dout_oe_n_reg && sout_reg && !int_out_reg && int_oe_n;
endproperty
a_oe_pulse: assert property (p_oe_pulse) else $error("read gave no data strobe");
a_oe_idle: assert property (p_oe_idle) else $error("stray data strobe");
a_iir_zero: assert property (p_iir_zero) else $error("iir high bits set");
a_ier_ones: assert property (p_ier_ones) else $error("ier high bits not one");
a_off_idle: assert property (p_off_idle) else $error("iir reports while disabled");
a_int_off: assert property (p_int_off) else $error("interrupt while disabled");
a_mcr_pins: assert property (p_mcr_pins) else $error("mcr outputs wrong");
a_break: assert property (p_break) else $error("break not at space");
a_scratch: assert property (p_scratch) else $error("offset 7 not zero");
a_reset: assert property (p_reset) else $error("reset outputs wrong");
endmodule // uart_lc_asserts
bind uart_irq_and_line_control uart_lc_asserts u_asserts (.clk(clk), .srst(srst), .ce(ce),
  .cs(cs), .addr(addr), .rd(rd), .wr(wr), .din(din), .dout_reg(dout_reg),
  .dout_oe_n_reg(dout_oe_n_reg), .sin(sin), .sout_reg(sout_reg), .cts(cts), .dsr(dsr),
  .ri(ri), .dcd(dcd), .int_out_reg(int_out_reg), .int_oe_n(int_oe_n), .dtr(dtr),
  .rts(rts), .out1(out1));
